/* verilog/frs_pkg.sv */
// Shared constants and types for the floppy result status and reset block
package frs_pkg;

    // Step pulses a recalibrate may issue before track zero must show
    localparam logic [6:0] RECAL_STEP_LIMIT  = 7'h50;
    // Track number that marks a bad track in the sector ID
    localparam logic [7:0] BAD_TRACK_ID      = 8'hFF;

    // Completion codes in the first status byte
    localparam logic [1:0] TERM_NORMAL       = 2'h0;
    localparam logic [1:0] TERM_ABNORMAL     = 2'h1;
    localparam logic [1:0] TERM_INVALID      = 2'h2;
    localparam logic [1:0] TERM_POLLING      = 2'h3;

    // Field positions, first status byte
    localparam int TERM_CODE_LSB             = 6;
    localparam int POSITIONING_COMPLETE_BIT  = 5;
    localparam int EQUIPMENT_FAULT_BIT       = 4;
    localparam int HEAD_BIT                  = 2;
    // Field positions, second status byte
    localparam int SECTOR_BEYOND_BIT         = 7;
    localparam int CRC_FAULT_ANY_FIELD_BIT   = 5;
    localparam int SERVICE_OVERRUN_BIT       = 4;
    localparam int SECTOR_MISSING_BIT        = 2;
    localparam int WRITE_PROTECTED_ABORT_BIT = 1;
    localparam int ADDRESS_SYNC_ABSENT_BIT   = 0;
    // Field positions, third status byte
    localparam int DELETED_MARK_SEEN_BIT     = 6;
    localparam int DATA_FIELD_CRC_FAULT_BIT  = 5;
    localparam int TRACK_MISMATCH_BIT        = 4;
    localparam int BAD_TRACK_FLAG_BIT        = 1;
    localparam int DATA_SYNC_ABSENT_BIT      = 0;
    // Field positions, fourth status byte
    localparam int WP_STATE_BIT              = 6;
    localparam int FIXED_ONE_HI_BIT          = 5;
    localparam int TRACK_ZERO_STATE_BIT      = 4;
    localparam int FIXED_ONE_LO_BIT          = 3;
    localparam int HEAD_LINE_STATE_BIT       = 2;

    // Result byte indices
    localparam logic [1:0] IDX_TERMINATION   = 2'h0;
    localparam logic [1:0] IDX_TRANSFER      = 2'h1;
    localparam logic [1:0] IDX_FIELD         = 2'h2;
    localparam logic [1:0] IDX_DRIVE_PIN     = 2'h3;

    // Reset values
    localparam logic       DOR_RESET_INIT    = 1'b1;
    localparam logic       POLL_EN_INIT      = 1'b1;
    localparam logic [7:0] RESULT_DATA_INIT  = 8'h00;

    // Which status bytes a command returns
    typedef enum logic [1:0] {
        FRS_RK_THREE  = 2'h0,
        FRS_RK_TERM   = 2'h1,
        FRS_RK_DRIVE  = 2'h2
    } frs_kind_t;

    typedef enum logic [2:0] {
        FRS_IDLE   = 3'b001,
        FRS_EXEC   = 3'b010,
        FRS_RESULT = 3'b100
    } frs_state_t;

    // One-cycle events from the execution engine
    typedef struct packed {
        logic positioning_complete;
        logic past_track_zero;
        logic sector_beyond;
        logic crc_id_field;
        logic crc_data_field;
        logic service_overrun;
        logic sector_missing;
        logic address_sync_absent;
        logic data_sync_absent;
        logic mark_seen;
        logic mark_deleted;
        logic id_track_valid;
    } frs_event_t;

    // Latched status flags
    typedef struct packed {
        logic positioning_complete;
        logic equipment_fault;
        logic sector_beyond;
        logic crc_fault_any_field;
        logic service_overrun;
        logic sector_missing;
        logic write_protected_abort;
        logic address_sync_absent;
        logic deleted_mark_seen;
        logic data_field_crc_fault;
        logic track_mismatch;
        logic bad_track_flag;
        logic data_sync_absent;
    } frs_flags_t;

endpackage : frs_pkg

/* verilog/frs_result_status.sv */
// Result status bytes and reset control of the floppy controller core
// Notes on behaviour
// - First byte bits 7:6 give completion: normal, abnormal, invalid, polling abnormal.
// - First byte bit 5 set when seek, relative seek or recalibrate completes.
// - Bit 4 set if track zero absent after 80 steps, or seek passes zero.
// - First byte: bit 3 zero, bit 2 head, bits 1:0 selected drive.
// - Second byte bit 7: sector past track end, or read/write ends without count.
// - Second byte bit 5 set on CRC fault in ID or data field.
// - Second byte bit 4 set when host or DMA misses transfer service.
// - Second byte bit 2 set when sector, ID field or sector sequence is missing.
// - Second byte bit 1 set when write protect is active during a write command.
// - Second byte bit 0 set when ID mark or data mark is not found.
// - Unused bits 6,3 of second byte and 7,3,2 of third read zero.
// - Third byte bit 6 set when the data mark type opposes the read command.
// - Third byte bit 5 set on CRC fault in the data field.
// - Third byte bit 4 set when ID track differs from held track.
// - Third byte bit 1 set when ID track differs and equals FF.
// - Third byte bit 0 set when no data or deleted data mark is found.
// - Fourth byte shows live pins: protect, track zero, head, drive; bit 7 zero.
// - Fourth byte bits 5 and 3 always read one.
// - Pin, output register bit or rate register bit reset; all leave power down.
// - Any reset aborts the operation in progress and returns to idle.
// - Leaving reset clears configuration and restarts polling until configure disables it.
// - Status bytes are handed to the host through the data register in result phase.
// - Rate reset clears itself; output register reset holds, is pin-set and wins.
// - Pin reset clears all registers except output register reset bit, polling enable and reset-seen flag, which it sets.
module frs_result_status
    import frs_pkg::*;
(
    // Clock and hardware reset pin
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Host data register read and software resets
    input  wire logic       data_rd_stb,
    input  wire logic       dor_wr_stb,
    input  wire logic       dor_reset_bit,
    input  wire logic       dsr_reset_stb,
    output logic [7:0]      result_data,
    output logic            host_request_flag,
    output logic            transfer_direction_flag,
    // Command sequencing from the core
    input  wire logic       cmd_start,
    input  wire logic       cmd_is_read_deleted,
    input  wire logic       cmd_is_rw_data,
    input  wire logic       cmd_is_write,
    input  wire logic       cmd_done,
    input  wire logic [1:0] termination_code,
    input  frs_kind_t       result_kind,
    input  frs_event_t      exec_event,
    input  wire logic [7:0] id_track,
    input  wire logic [7:0] held_track,
    input  wire logic       recal_active,
    input  wire logic       recal_step,
    input  wire logic       cur_head,
    input  wire logic [1:0] cur_unit,
    // Power and configuration control
    input  wire logic       power_down_req,
    input  wire logic       poll_disable_stb,
    output logic            core_reset,
    output logic            power_down,
    output logic            polling_enable,
    output logic            config_clear,
    // Drive cable pins, asynchronous
    input  wire logic       write_protect_pin,
    input  wire logic       track_zero_sensor,
    input  wire logic       head_choice_pin,
    input  wire logic [1:0] unit_select,
    input  wire logic       terminal_count
);

    // Pin synchronisers: first stage feeds only the second
    logic [5:0] pin_meta_ff;
    logic [5:0] pin_sync_ff;
    logic [5:0] nxt_pin_meta;
    logic [5:0] nxt_pin_sync;
    logic       wp_s;
    logic       track_zero_sensor_s;
    logic       head_s;
    logic [1:0] unit_s;
    logic       tc_s;

    always_comb
    begin
        nxt_pin_meta = {terminal_count, unit_select, head_choice_pin, track_zero_sensor, write_protect_pin};
        nxt_pin_sync = pin_meta_ff;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_ff <= 6'h00;
            pin_sync_ff <= 6'h00;
        end
        else
        begin
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
        end
    end

    assign wp_s   = pin_sync_ff[0];
    assign track_zero_sensor_s = pin_sync_ff[1];
    assign head_s = pin_sync_ff[2];
    assign unit_s = pin_sync_ff[4:3];
    assign tc_s   = pin_sync_ff[5];

    // Reset sources; the output register bit is preset by the pin
    logic dor_rst_ff;
    logic dsr_rst_ff;
    logic pd_ff;
    logic poll_ff;
    logic rst_seen_ff;
    logic nxt_dor_rst;
    logic nxt_dsr_rst;
    logic nxt_pd;
    logic nxt_poll;
    logic nxt_rst_seen;

    always_comb
    begin
        nxt_dor_rst  = dor_wr_stb ? dor_reset_bit : dor_rst_ff;
        nxt_dsr_rst  = dsr_reset_stb;
        nxt_rst_seen = core_reset;
        // Any reset forces power up; a request during reset is dropped
        nxt_pd       = core_reset ? 1'b0 : (pd_ff | power_down_req);
        // Polling restarts on every reset, only configure turns it off
        nxt_poll     = core_reset ? POLL_EN_INIT : (poll_ff & ~poll_disable_stb);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dor_rst_ff  <= DOR_RESET_INIT;
            dsr_rst_ff  <= 1'b0;
            pd_ff       <= 1'b0;
            poll_ff     <= POLL_EN_INIT;
            rst_seen_ff <= 1'b1;
        end
        else
        begin
            dor_rst_ff  <= nxt_dor_rst;
            dsr_rst_ff  <= nxt_dsr_rst;
            pd_ff       <= nxt_pd;
            poll_ff     <= nxt_poll;
            rst_seen_ff <= nxt_rst_seen;
        end
    end

    // Either software bit resets the core; the held bit dominates
    assign core_reset     = dor_rst_ff | dsr_rst_ff;
    assign power_down     = pd_ff;
    assign polling_enable = poll_ff;
    // One pulse on the release so configure state is wiped
    assign config_clear   = rst_seen_ff & ~core_reset;

    // Command phase tracking and result sequencing
    frs_state_t state_ff;
    frs_state_t nxt_state;
    logic [1:0] res_idx_ff;
    logic [1:0] nxt_res_idx;
    frs_kind_t  kind_ff;
    frs_kind_t  nxt_kind;
    logic [7:0] res_data_ff;
    logic [7:0] nxt_res_data;
    logic       rd_ok;
    logic       last_byte;

    assign rd_ok     = data_rd_stb & (state_ff == FRS_RESULT);
    assign last_byte = (kind_ff != FRS_RK_THREE) | (res_idx_ff == IDX_FIELD);

    // Status flag latches
    frs_flags_t flags_ff;
    frs_flags_t nxt_flags;
    logic [1:0] term_ff;
    logic       head_ff;
    logic [1:0] unit_ff;
    logic       tc_seen_ff;
    logic [6:0] step_cnt_ff;
    logic [1:0] nxt_term;
    logic       nxt_head;
    logic [1:0] nxt_unit;
    logic       nxt_tc_seen;
    logic [6:0] nxt_step_cnt;
    logic       flag_clr;
    logic       in_exec;

    assign in_exec  = (state_ff == FRS_EXEC);
    assign flag_clr = cmd_start | core_reset;

    // Build one result byte; unused bits are fixed
    function automatic logic [7:0] status_byte(input logic [1:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            IDX_TERMINATION:
            begin
                b[TERM_CODE_LSB+:2]            = term_ff;
                b[POSITIONING_COMPLETE_BIT]    = flags_ff.positioning_complete;
                b[EQUIPMENT_FAULT_BIT]         = flags_ff.equipment_fault;
                b[HEAD_BIT]                    = head_ff;
                b[1:0]                         = unit_ff;
            end
            IDX_TRANSFER:
            begin
                b[SECTOR_BEYOND_BIT]           = flags_ff.sector_beyond;
                b[CRC_FAULT_ANY_FIELD_BIT]     = flags_ff.crc_fault_any_field;
                b[SERVICE_OVERRUN_BIT]         = flags_ff.service_overrun;
                b[SECTOR_MISSING_BIT]          = flags_ff.sector_missing;
                b[WRITE_PROTECTED_ABORT_BIT]   = flags_ff.write_protected_abort;
                b[ADDRESS_SYNC_ABSENT_BIT]     = flags_ff.address_sync_absent;
            end
            IDX_FIELD:
            begin
                b[DELETED_MARK_SEEN_BIT]       = flags_ff.deleted_mark_seen;
                b[DATA_FIELD_CRC_FAULT_BIT]    = flags_ff.data_field_crc_fault;
                b[TRACK_MISMATCH_BIT]          = flags_ff.track_mismatch;
                b[BAD_TRACK_FLAG_BIT]          = flags_ff.bad_track_flag;
                b[DATA_SYNC_ABSENT_BIT]        = flags_ff.data_sync_absent;
            end
            IDX_DRIVE_PIN:
            begin
                b[WP_STATE_BIT]                = wp_s;
                b[FIXED_ONE_HI_BIT]            = 1'b1;
                b[TRACK_ZERO_STATE_BIT]        = track_zero_sensor_s;
                b[FIXED_ONE_LO_BIT]            = 1'b1;
                b[HEAD_LINE_STATE_BIT]         = head_s;
                b[1:0]                         = unit_s;
            end
        endcase
        return b;
    endfunction : status_byte

    // Flags: an event in the clearing cycle still sets its flag
    always_comb
    begin
        logic mismatch;
        mismatch     = exec_event.id_track_valid & (id_track != held_track);
        nxt_flags    = flag_clr ? '0 : flags_ff;
        nxt_step_cnt = (flag_clr | ~recal_active | track_zero_sensor_s) ? 7'h00 : step_cnt_ff;
        nxt_tc_seen  = (flag_clr ? 1'b0 : tc_seen_ff) | (in_exec & tc_s);
        if (in_exec & recal_step & recal_active & ~track_zero_sensor_s & (step_cnt_ff != RECAL_STEP_LIMIT))
            nxt_step_cnt = step_cnt_ff + 7'h01;
        nxt_flags.positioning_complete  |= exec_event.positioning_complete;
        nxt_flags.equipment_fault       |= exec_event.past_track_zero
                                        | (recal_active & ~track_zero_sensor_s & (step_cnt_ff == RECAL_STEP_LIMIT));
        nxt_flags.sector_beyond         |= exec_event.sector_beyond
                                        | (in_exec & cmd_done & cmd_is_rw_data & ~tc_seen_ff & ~tc_s);
        nxt_flags.crc_fault_any_field   |= exec_event.crc_id_field | exec_event.crc_data_field;
        nxt_flags.service_overrun       |= exec_event.service_overrun;
        nxt_flags.sector_missing        |= exec_event.sector_missing;
        nxt_flags.write_protected_abort |= in_exec & cmd_is_write & wp_s;
        nxt_flags.address_sync_absent   |= exec_event.address_sync_absent
                                        | exec_event.data_sync_absent;
        nxt_flags.deleted_mark_seen     |= exec_event.mark_seen
                                        & (exec_event.mark_deleted ^ cmd_is_read_deleted);
        nxt_flags.data_field_crc_fault  |= exec_event.crc_data_field;
        nxt_flags.track_mismatch        |= mismatch;
        nxt_flags.bad_track_flag        |= mismatch & (id_track == BAD_TRACK_ID);
        nxt_flags.data_sync_absent      |= exec_event.data_sync_absent;
        nxt_term = flag_clr ? TERM_NORMAL : term_ff;
        nxt_head = head_ff;
        nxt_unit = unit_ff;
        // Completion code and current head and drive caught at command end
        if (in_exec & cmd_done)
        begin
            nxt_term = termination_code;
            nxt_head = cur_head;
            nxt_unit = cur_unit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_ff    <= '0;
            term_ff     <= TERM_NORMAL;
            head_ff     <= 1'b0;
            unit_ff     <= 2'h0;
            tc_seen_ff  <= 1'b0;
            step_cnt_ff <= 7'h00;
        end
        else
        begin
            flags_ff    <= nxt_flags;
            term_ff     <= nxt_term;
            head_ff     <= nxt_head;
            unit_ff     <= nxt_unit;
            tc_seen_ff  <= nxt_tc_seen;
            step_cnt_ff <= nxt_step_cnt;
        end
    end

    // Phase machine; a core reset drops back to idle from anywhere
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_res_idx  = res_idx_ff;
        nxt_kind     = kind_ff;
        nxt_res_data = res_data_ff;
        unique case (state_ff)
            FRS_IDLE:
            begin
                if (cmd_start)
                    nxt_state = FRS_EXEC;
            end
            FRS_EXEC:
            begin
                if (cmd_done)
                begin
                    nxt_state   = FRS_RESULT;
                    nxt_kind    = result_kind;
                    nxt_res_idx = (result_kind == FRS_RK_DRIVE) ? IDX_DRIVE_PIN : IDX_TERMINATION;
                end
            end
            FRS_RESULT:
            begin
                // Byte is refreshed every cycle so pins stay live
                nxt_res_data = status_byte(res_idx_ff);
                if (rd_ok)
                begin
                    if (last_byte)
                        nxt_state = FRS_IDLE;
                    else
                        nxt_res_idx = res_idx_ff + 2'h1;
                end
            end
            default:
                nxt_state = FRS_IDLE;
        endcase
        if (core_reset)
        begin
            nxt_state    = FRS_IDLE;
            nxt_res_data = RESULT_DATA_INIT;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= FRS_IDLE;
            res_idx_ff  <= IDX_TERMINATION;
            kind_ff     <= FRS_RK_THREE;
            res_data_ff <= RESULT_DATA_INIT;
        end
        else
        begin
            state_ff    <= nxt_state;
            res_idx_ff  <= nxt_res_idx;
            kind_ff     <= nxt_kind;
            res_data_ff <= nxt_res_data;
        end
    end

    // Request and direction are only meaningful together in result phase
    assign result_data             = res_data_ff;
    assign host_request_flag       = (state_ff == FRS_RESULT) & ~core_reset;
    assign transfer_direction_flag = (state_ff == FRS_RESULT);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_read_in_result;
        rd_ok;
    endsequence
    sequence s_enter_exec;
        (state_ff == FRS_IDLE) && cmd_start && !core_reset;
    endsequence

    property p_reset_idle;
        core_reset |=> state_ff == FRS_IDLE && !host_request_flag;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset did not abort");

    property p_dsr_self_clear;
        dsr_reset_stb && !dor_rst_ff && !(dor_wr_stb && dor_reset_bit) |=> core_reset ##1 !core_reset;
    endproperty
    a_dsr_self_clear: assert property (p_dsr_self_clear) else $error("rate reset not self clearing");

    property p_dor_hold;
        dor_rst_ff && !dor_wr_stb |=> core_reset;
    endproperty
    a_dor_hold: assert property (p_dor_hold) else $error("output register reset dropped");

    property p_pd_exit;
        core_reset |=> !power_down;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("reset left power down");

    property p_flag_clear;
        s_enter_exec |=> flags_ff == '0 || $past(exec_event) != '0 || $past(in_exec);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared at start");

    property p_fixed_ones;
        state_ff == FRS_RESULT && $past(state_ff) == FRS_RESULT && res_idx_ff == IDX_DRIVE_PIN
            && $past(res_idx_ff) == IDX_DRIVE_PIN && !$past(core_reset)
            |-> result_data[FIXED_ONE_HI_BIT] && result_data[FIXED_ONE_LO_BIT] && !result_data[7];
    endproperty
    a_fixed_ones: assert property (p_fixed_ones) else $error("fourth byte fixed bits wrong");

    property p_unused_zero;
        state_ff == FRS_RESULT && $past(state_ff) == FRS_RESULT && res_idx_ff == IDX_TRANSFER
            && $past(res_idx_ff) == IDX_TRANSFER |-> result_data[6] == 1'b0 && result_data[3] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("second byte unused bit set");

    property p_three_bytes;
        state_ff == FRS_RESULT && kind_ff == FRS_RK_THREE && res_idx_ff == IDX_TERMINATION && !core_reset
            ##0 s_read_in_result |=> res_idx_ff == IDX_TRANSFER && state_ff == FRS_RESULT;
    endproperty
    a_three_bytes: assert property (p_three_bytes) else $error("result index did not advance");

    property p_bad_track;
        exec_event.id_track_valid && id_track == BAD_TRACK_ID && held_track != BAD_TRACK_ID && !flag_clr
            |=> flags_ff.bad_track_flag && flags_ff.track_mismatch;
    endproperty
    a_bad_track: assert property (p_bad_track) else $error("bad track not flagged");

    property p_poll_restart;
        core_reset |=> polling_enable [*1] ##0 !power_down;
    endproperty
    a_poll_restart: assert property (p_poll_restart) else $error("polling not restarted");

endmodule : frs_result_status

/* testbench/frs_host_model.sv */
// Host reader model that takes result bytes from the data register
module frs_host_model (
    // Clock, reset and read trigger from the bench
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic rd_go,
    // Handshake with the block
    input  wire logic host_request_flag,
    input  wire logic transfer_direction_flag,
    output logic      data_rd_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    // One read pulse, only while request and read direction both stand
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            data_rd_stb <= 1'b0;
        else
            data_rd_stb <= rd_go && host_request_flag && transfer_direction_flag && !data_rd_stb;
    end
endmodule : frs_host_model

/* testbench/frs_result_status_test.sv */
// Self-checking bench for the result status and reset block
module frs_result_status_test import frs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst_n = 0, rd_go = 0, data_rd_stb, dor_wr_stb = 0, dor_reset_bit = 0;
    logic dsr_reset_stb = 0, cmd_start = 0, cmd_is_read_deleted = 0, cmd_is_rw_data = 0, cmd_is_write = 0;
    logic cmd_done = 0, recal_active = 0, recal_step = 0, cur_head = 0, power_down_req = 0;
    logic poll_disable_stb = 0, write_protect_pin = 1, track_zero_sensor = 1, head_choice_pin = 0;
    logic terminal_count = 0, host_request_flag, transfer_direction_flag, core_reset, power_down;
    logic polling_enable, config_clear;
    logic [1:0] termination_code = 2'h0, cur_unit = 2'h0, unit_select = 2'h1;
    logic [7:0] id_track = 8'hFF, held_track = 8'h05, result_data;
    frs_kind_t result_kind = FRS_RK_THREE;
    frs_event_t exec_event = '0;
    int error_cnt = 0, compares = 0, cyc = 0;
    frs_result_status frs_result_status_i (.*);
    frs_host_model frs_host_model_i (.*);
    // Free-running 25 MHz clock
    always #20 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // Command with one burst of execution events, ends on the cmd_done edge
    task automatic cmd(input frs_kind_t k, input logic [1:0] t, input logic [11:0] ev);
        @(posedge core_clk) cmd_start <= 1'b1;
        @(posedge core_clk) cmd_start <= 1'b0;
        exec_event <= frs_event_t'(ev);
        @(posedge core_clk) exec_event <= '0;
        cmd_done <= 1'b1;
        termination_code <= t;
        result_kind <= k;
        @(posedge core_clk) cmd_done <= 1'b0;
    endtask : cmd
    // Byte is valid one edge after the index moves, so wait before looking
    task automatic rd(input string n, input logic [7:0] e);
        repeat (2) @(posedge core_clk);
        #1 chk("request", 8'h01, {7'h00, host_request_flag & transfer_direction_flag});
        chk(n, e, result_data);
        @(posedge core_clk) rd_go <= 1'b1;
        @(posedge core_clk) rd_go <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : rd
    // Hang guard, the whole run needs under a hundred cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk) #1;
        chk("core_reset", 8'h01, {7'h00, core_reset});
        chk("polling", 8'h01, {7'h00, polling_enable});
        chk("power_down", 8'h00, {7'h00, power_down});
        @(posedge core_clk) dor_wr_stb <= 1'b1;
        @(posedge core_clk) dor_wr_stb <= 1'b0;
        #1 chk("core_reset", 8'h00, {7'h00, core_reset});
        chk("config_clear", 8'h01, {7'h00, config_clear});
        @(posedge core_clk) #1 chk("config_clear", 8'h00, {7'h00, config_clear});
        cur_head <= 1'b1;
        cur_unit <= 2'h2;
        cmd_is_rw_data <= 1'b1;
        cmd(FRS_RK_THREE, TERM_ABNORMAL, 12'h181);
        rd("termination", 8'h46);
        rd("transfer", 8'hA0);
        rd("field", 8'h32);
        #1 chk("request", 8'h00, {7'h00, host_request_flag});
        cmd_is_rw_data <= 1'b0;
        cur_head <= 1'b0;
        cur_unit <= 2'h1;
        cmd(FRS_RK_TERM, TERM_NORMAL, 12'h800);
        rd("seek end", 8'h21);
        cmd(FRS_RK_DRIVE, TERM_NORMAL, 12'h000);
        rd("drive pins", 8'h79);
        // Write command that meets protect, overrun and a deleted mark
        cmd_is_write <= 1'b1;
        cmd(FRS_RK_THREE, TERM_ABNORMAL, 12'h47E);
        rd("termination", 8'h51);
        rd("transfer", 8'h17);
        rd("field", 8'h41);
        cmd_is_write <= 1'b0;
        @(posedge core_clk) power_down_req <= 1'b1;
        poll_disable_stb <= 1'b1;
        @(posedge core_clk) power_down_req <= 1'b0;
        poll_disable_stb <= 1'b0;
        #1 chk("power_down", 8'h01, {7'h00, power_down});
        chk("polling", 8'h00, {7'h00, polling_enable});
        // Rate reset in the middle of a result phase must abort it
        cmd(FRS_RK_THREE, TERM_ABNORMAL, 12'h000);
        @(posedge core_clk) dsr_reset_stb <= 1'b1;
        @(posedge core_clk) dsr_reset_stb <= 1'b0;
        #1 chk("dsr reset", 8'h01, {7'h00, core_reset});
        chk("request", 8'h00, {7'h00, host_request_flag});
        @(posedge core_clk) #1 chk("dsr reset", 8'h00, {7'h00, core_reset});
        chk("abort", 8'h00, {7'h00, transfer_direction_flag});
        chk("abort data", 8'h00, result_data);
        chk("power_down", 8'h00, {7'h00, power_down});
        chk("polling", 8'h01, {7'h00, polling_enable});
        chk("config_clear", 8'h01, {7'h00, config_clear});
        tally_and_finish();
    end
endmodule : frs_result_status_test
